// [hw/cpu_bus_pkg.sv]
// Purpose: shared constants and carriers for the external operation interface
// Assumes: 200 MHz system clock, emulated processor clock of 800 ns period
// Notes: one processor cycle is six half-period phases
package cpu_bus_pkg;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PCLK_PERIOD_NS = 800;
   localparam int HALF_CYCLES = (PCLK_PERIOD_NS * 1000 / 2) / CLK_PERIOD_PS;
   localparam int PERIODS_PER_CYCLE = 3;
   localparam int PHASES_PER_CYCLE = 2 * PERIODS_PER_CYCLE;
   localparam int REQ_PHASES = PHASES_PER_CYCLE / 2;
   localparam int PHASE_W = 3;
   localparam logic [PHASE_W-1:0] PH_START = 3'h0;
   localparam logic [PHASE_W-1:0] PH_REQ_LAST = 3'(REQ_PHASES - 1);
   localparam logic [PHASE_W-1:0] PH_LAST = 3'(PHASES_PER_CYCLE - 1);
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int ADDR_DC_BIT = 14;
   localparam int ADDR_EXT_BIT = 13;
   localparam int EXT_ADDR_W = 8;
   localparam logic [ADDR_W-1:0] RESET_VECTOR = 15'h0000;

   typedef enum logic [1:0] {form_mem, form_io_ctrl, form_io_data, form_io_ext} op_form_e;

   typedef struct packed {
      op_form_e form;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic last;
      logic halt;
      logic flag_wr;
      logic flag_val;
   } op_cmd_s;

   typedef struct packed {
      logic request;
      logic mem_io;
      logic write;
      logic irq_accept;
      logic [ADDR_W-1:0] addr;
   } bus_ctl_s;

   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
      logic boot;
      logic vector;
   } rd_s;
endpackage

// [hw/phase_gen.sv]
// Purpose: half-period phase sequencer of the emulated processor clock
// Assumes: hold is only raised while waiting for the acknowledge
// Notes: the half counter never stops, so a released hold steps at the next half edge
module phase_gen #(
   parameter int HALF_CYC = cpu_bus_pkg::HALF_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hold,
   output logic step,
   output logic [cpu_bus_pkg::PHASE_W-1:0] phase
);
   import cpu_bus_pkg::*;
   localparam int CW = $clog2(HALF_CYC + 1);
   localparam logic [CW-1:0] HALF_END = CW'(HALF_CYC - 1);

   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic [PHASE_W-1:0] phase_ff, nxt_phase;

   always_comb
   begin
      step = (cnt_ff == HALF_END) && !hold;
      nxt_cnt = (cnt_ff == HALF_END) ? '0 : cnt_ff + 1'b1;
      nxt_phase = phase_ff;
      if (step)
      begin
         nxt_phase = (phase_ff == PH_LAST) ? PH_START : phase_ff + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_ff <= '0;
         phase_ff <= PH_LAST;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         phase_ff <= nxt_phase;
      end
   end

   assign phase = phase_ff;
endmodule

// [hw/wait_ctl.sv]
// Purpose: run and wait status tracking
// Assumes: instruction boundaries arrive as one-cycle pulses
// Notes: while running, pause is only looked at on a boundary, so a short pause is absorbed
module wait_ctl (
   input wire logic clk,
   input wire logic rst,
   input wire logic instr_end,
   input wire logic halt_end,
   input wire logic pause_n,
   input wire logic irq_wake,
   output logic running,
   output logic halted
);
   typedef enum logic [1:0] {st_run, st_wait_halt, st_wait_pause} wait_e;
   wait_e st_ff, nxt_st;
   // status pin comes from its own flop, so a state decode never glitches it
   logic run_ff, nxt_run;

   always_comb
   begin
      nxt_st = st_ff;
      case (st_ff)
         st_run:
         begin
            if (halt_end)
            begin
               nxt_st = st_wait_halt;
            end
            else if (instr_end && !pause_n)
            begin
               nxt_st = st_wait_pause;
            end
         end
         st_wait_halt:
         begin
            if (irq_wake)
            begin
               nxt_st = st_run;
            end
         end
         st_wait_pause:
         begin
            if (pause_n)
            begin
               nxt_st = st_run;
            end
         end
         default: nxt_st = st_run;
      endcase
      nxt_run = (nxt_st == st_run);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= st_run;
         run_ff <= 1'b1;
      end
      else
      begin
         st_ff <= nxt_st;
         run_ff <= nxt_run;
      end
   end

   assign running = run_ff;
   assign halted = (st_ff == st_wait_halt);
endmodule

// [hw/cpu_external_bus_handshake.sv]
// Purpose: external operation request and qualifier sequencing of an 8-bit processor
// Assumes: op_done_n, pause_n and irq_request_n are synchronous to clk
// Notes: the execution core is outside; it feeds one bus operation per cycle
// Operation
// - outputs steady during request, strobe excepted
// - request held until acknowledge, activity suspended
// - interrupt acknowledged after instruction, with request
// - interrupt accept drops after its acknowledge
// - memory/io qualifier high for memory
// - write qualifier high for writes, sets direction
// - control forms low, data forms high
// - bit fourteen carries data/control during io
// - bit thirteen carries two-byte flag during io
// - two-byte io high, low byte carries address
// - run high executing, low waiting
// - halt leaves on interrupt, pause on release
// - reset under pause fetches once, then waits
// - flag output follows status flag bit
// - write strobe low in first and last request phases of a write, high mid write and for reads
// - processor cycle is three clock periods
// - request high half cycle, low half
// - acknowledge is active low
// - late acknowledge stalls with outputs frozen
module cpu_external_bus_handshake #(
   parameter int HALF_CYC = cpu_bus_pkg::HALF_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic op_valid,
   input cpu_bus_pkg::op_cmd_s op_cmd,
   output logic op_ready,
   output cpu_bus_pkg::rd_s rd_out,
   input wire logic irq_enable,
   input wire logic op_done_n,
   input wire logic irq_request_n,
   input wire logic pause_n,
   input wire logic [cpu_bus_pkg::DATA_W-1:0] data_lines_in,
   output logic [cpu_bus_pkg::DATA_W-1:0] data_lines_out,
   output logic data_lines_oe,
   output cpu_bus_pkg::bus_ctl_s bus_ctl,
   output logic write_strobe_pulse,
   output logic run_status,
   output logic flag_out
);
   import cpu_bus_pkg::*;

   typedef enum logic {st_idle, st_req} seq_e;
   typedef enum logic [1:0] {src_user, src_boot, src_vector} src_e;

   localparam int REQ_CLKS = REQ_PHASES * HALF_CYC;
   localparam int CYCLE_CLKS = PHASES_PER_CYCLE * HALF_CYC;

   function automatic logic [ADDR_W-1:0] build_addr(op_form_e form, logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] r;
      r = '0;
      if (form == form_mem)
      begin
         r = a;
      end
      else
      begin
         r[ADDR_DC_BIT] = (form == form_io_data);
         r[ADDR_EXT_BIT] = (form == form_io_ext);
         if (form == form_io_ext)
         begin
            r[EXT_ADDR_W-1:0] = a[EXT_ADDR_W-1:0];
         end
      end
      return r;
   endfunction

   seq_e st_ff, nxt_st;
   src_e src_ff, nxt_src;
   op_cmd_s cur_ff, nxt_cur;
   bus_ctl_s ctl_ff, nxt_ctl;
   rd_s rd_ff, nxt_rd;
   logic [DATA_W-1:0] dout_ff, nxt_dout;
   logic doe_ff, nxt_doe, wsp_ff, nxt_wsp, flag_ff, nxt_flag, ready_ff, nxt_ready;
   logic boot_ff, nxt_boot, irq_due_ff, nxt_irq_due, inhibit_ff, nxt_inhibit;
   logic step, hold, cyc_start, req_end, instr_end, halt_end, irq_ok;
   logic running, halted;
   logic [PHASE_W-1:0] phase;

   // acknowledge is sampled only at the end of the request half
   assign hold = (st_ff == st_req) && (phase == PH_REQ_LAST) && op_done_n;
   assign cyc_start = step && (phase == PH_LAST);
   assign req_end = step && (phase == PH_REQ_LAST) && (st_ff == st_req);
   assign irq_ok = !irq_request_n && !inhibit_ff;

   phase_gen #(.HALF_CYC(HALF_CYC)) u_phase (
      .clk(clk),
      .rst(rst),
      .hold(hold),
      .step(step),
      .phase(phase)
   );

   wait_ctl u_wait (
      .clk(clk),
      .rst(rst),
      .instr_end(instr_end),
      .halt_end(halt_end),
      .pause_n(pause_n),
      .irq_wake(irq_due_ff),
      .running(running),
      .halted(halted)
   );

   always_comb
   begin
      nxt_st = st_ff;
      nxt_src = src_ff;
      nxt_cur = cur_ff;
      nxt_ctl = ctl_ff;
      nxt_dout = dout_ff;
      nxt_doe = doe_ff;
      nxt_wsp = wsp_ff;
      nxt_flag = flag_ff;
      nxt_boot = boot_ff;
      nxt_irq_due = irq_due_ff;
      nxt_inhibit = inhibit_ff;
      nxt_ready = 1'b0;
      nxt_rd = rd_ff;
      nxt_rd.valid = 1'b0;
      instr_end = 1'b0;
      halt_end = 1'b0;
      if (irq_enable)
      begin
         nxt_inhibit = 1'b0;
      end
      case (st_ff)
         st_idle:
         begin
            if (cyc_start && (boot_ff || (running && (irq_due_ff || op_valid))))
            begin
               nxt_st = st_req;
               nxt_ctl.request = 1'b1;
               if (boot_ff)
               begin
                  // first bus activity after reset is the boot fetch
                  nxt_src = src_boot;
                  nxt_cur = '0;
                  nxt_cur.addr = RESET_VECTOR;
               end
               else if (irq_due_ff)
               begin
                  // vector read is an io read flagged by the accept line
                  nxt_src = src_vector;
                  nxt_cur = '0;
                  nxt_cur.form = form_io_ctrl;
                  nxt_irq_due = 1'b0;
                  nxt_inhibit = 1'b1;
               end
               else
               begin
                  nxt_src = src_user;
                  nxt_cur = op_cmd;
                  nxt_ready = 1'b1;
               end
               nxt_ctl.irq_accept = !boot_ff && irq_due_ff;
               nxt_ctl.mem_io = boot_ff || (!irq_due_ff && op_cmd.form == form_mem);
               nxt_ctl.write = !boot_ff && !irq_due_ff && op_cmd.write;
               nxt_ctl.addr = (boot_ff || irq_due_ff) ? build_addr(boot_ff ? form_mem :
                  form_io_ctrl, RESET_VECTOR) : build_addr(op_cmd.form, op_cmd.addr);
               nxt_doe = nxt_ctl.write;
               nxt_dout = op_cmd.wdata;
               nxt_wsp = !nxt_ctl.write;
            end
         end
         st_req:
         begin
            if (step)
            begin
               // strobe is the only output that moves under request
               nxt_wsp = (phase == PH_START) || !ctl_ff.write;
            end
            if (req_end)
            begin
               // request ends the half cycle, accept drops only with the acknowledge
               nxt_st = st_idle;
               nxt_ctl.request = 1'b0;
               nxt_ctl.irq_accept = 1'b0;
               nxt_doe = 1'b0;
               nxt_wsp = 1'b1;
               if (!ctl_ff.write)
               begin
                  nxt_rd.valid = 1'b1;
                  nxt_rd.data = data_lines_in;
                  nxt_rd.boot = (src_ff == src_boot);
                  nxt_rd.vector = (src_ff == src_vector);
               end
               if (src_ff == src_boot)
               begin
                  nxt_boot = 1'b0;
                  instr_end = 1'b1;
               end
               else if (src_ff == src_user && cur_ff.last)
               begin
                  instr_end = 1'b1;
                  halt_end = cur_ff.halt;
                  if (cur_ff.flag_wr)
                  begin
                     nxt_flag = cur_ff.flag_val;
                  end
               end
            end
         end
         default: nxt_st = st_idle;
      endcase
      // pending interrupt is caught at a boundary or while halted
      if (irq_ok && (instr_end || halted))
      begin
         nxt_irq_due = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= st_idle;
         src_ff <= src_user;
         cur_ff <= '0;
         ctl_ff <= '0;
         rd_ff <= '0;
         dout_ff <= '0;
         doe_ff <= 1'b0;
         wsp_ff <= 1'b1;
         flag_ff <= 1'b0;
         ready_ff <= 1'b0;
         boot_ff <= 1'b1;
         irq_due_ff <= 1'b0;
         inhibit_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         src_ff <= nxt_src;
         cur_ff <= nxt_cur;
         ctl_ff <= nxt_ctl;
         rd_ff <= nxt_rd;
         dout_ff <= nxt_dout;
         doe_ff <= nxt_doe;
         wsp_ff <= nxt_wsp;
         flag_ff <= nxt_flag;
         ready_ff <= nxt_ready;
         boot_ff <= nxt_boot;
         irq_due_ff <= nxt_irq_due;
         inhibit_ff <= nxt_inhibit;
      end
   end

   assign bus_ctl = ctl_ff;
   assign data_lines_out = dout_ff;
   assign data_lines_oe = doe_ff;
   assign write_strobe_pulse = wsp_ff;
   assign flag_out = flag_ff;
   assign op_ready = ready_ff;
   assign rd_out = rd_ff;
   assign run_status = running;

   // helper counters for timing checks; a stall voids the nominal figures
   logic [9:0] cyc_cnt_ff, req_cnt_ff;
   logic stalled_ff, seen_ff;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cyc_cnt_ff <= '0;
         req_cnt_ff <= '0;
         stalled_ff <= 1'b0;
         seen_ff <= 1'b0;
      end
      else
      begin
         cyc_cnt_ff <= cyc_start ? '0 : cyc_cnt_ff + 1'b1;
         req_cnt_ff <= ctl_ff.request ? req_cnt_ff + 1'b1 : '0;
         stalled_ff <= cyc_start ? 1'b0 : (stalled_ff || hold);
         seen_ff <= seen_ff || cyc_start;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence req_rise;
      $rose(ctl_ff.request);
   endsequence
   sequence req_drop;
      $fell(ctl_ff.request);
   endsequence

   chk_req_steady: assert property (ctl_ff.request && $past(ctl_ff.request) |->
      $stable(ctl_ff.addr) && $stable(ctl_ff.write) && $stable(ctl_ff.mem_io) && $stable(dout_ff))
      else $error("bus output moved under request");
   chk_ack_gate: assert property (req_drop |-> $past(!op_done_n))
      else $error("request dropped without acknowledge");
   chk_late_stall: assert property (hold |=> $stable(phase) && ctl_ff.request)
      else $error("phase advanced while waiting for acknowledge");
   chk_accept_pair: assert property (ctl_ff.irq_accept |-> ctl_ff.request && !ctl_ff.write)
      else $error("interrupt accept outside a read request");
   chk_accept_drop: assert property ($fell(ctl_ff.irq_accept) |-> $fell(ctl_ff.request))
      else $error("interrupt accept dropped before acknowledge");
   chk_dir_follow: assert property (ctl_ff.request |-> doe_ff == ctl_ff.write)
      else $error("data direction disagrees with write qualifier");
   chk_io_encode: assert property (ctl_ff.request && !ctl_ff.mem_io && !ctl_ff.irq_accept |->
      ctl_ff.addr[ADDR_DC_BIT] == (cur_ff.form == form_io_data) &&
      ctl_ff.addr[ADDR_EXT_BIT] == (cur_ff.form == form_io_ext))
      else $error("io qualifiers misencoded");
   chk_mem_sel: assert property (req_rise |-> ctl_ff.mem_io ==
      (src_ff == src_boot || (src_ff == src_user && cur_ff.form == form_mem)))
      else $error("memory qualifier wrong");
   chk_read_strobe: assert property (ctl_ff.request && !ctl_ff.write |-> wsp_ff)
      else $error("strobe low during read");
   chk_write_pulse: assert property ((req_rise and ctl_ff.write) |-> !wsp_ff)
      else $error("strobe high at write start");
   chk_cycle_len: assert property (cyc_start && seen_ff && !stalled_ff |->
      cyc_cnt_ff == 10'(CYCLE_CLKS - 1))
      else $error("processor cycle length wrong");
   chk_req_width: assert property ((req_drop and !stalled_ff) |->
      req_cnt_ff == 10'(REQ_CLKS))
      else $error("request width wrong");
   chk_boot_first: assert property (req_rise && $past(boot_ff) |->
      ctl_ff.mem_io && !ctl_ff.write && ctl_ff.addr == RESET_VECTOR)
      else $error("first request is not the boot fetch");
   chk_flag_hold: assert property (!$past(instr_end) |-> $stable(flag_ff))
      else $error("flag changed off a boundary");
endmodule

// [verif/op_responder.sv]
// Purpose: memory, io and interrupter model on the far side of the operation bus
// Assumes: bus_ctl and the data lines are registered outputs of the block
// Notes: read byte is the low address byte xor a5, interrupt vector is VEC
module op_responder #(
   parameter logic [7:0] VEC = 8'h3c,
   parameter int SLOW_DLY = 30
) (
   input wire logic clk,
   input wire logic rst,
   input cpu_bus_pkg::bus_ctl_s bus_ctl,
   input wire logic [cpu_bus_pkg::DATA_W-1:0] data_lines_out,
   input wire logic data_lines_oe,
   input wire logic slow,
   input wire logic irq_go,
   output logic op_done_n,
   output logic [cpu_bus_pkg::DATA_W-1:0] data_lines_in,
   output logic irq_request_n,
   output logic [cpu_bus_pkg::DATA_W-1:0] wdata_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   import cpu_bus_pkg::*;
   int cnt;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt <= 0;
         op_done_n <= 1'b1;
         data_lines_in <= 8'h00;
         irq_request_n <= 1'b1;
         wdata_seen <= 8'h00;
      end
      else
      begin
         if (irq_go)
            irq_request_n <= 1'b0;
         else if (bus_ctl.irq_accept)
            irq_request_n <= 1'b1;
         if (bus_ctl.request && op_done_n)
         begin
            cnt <= cnt + 1;
            if (cnt >= (slow ? SLOW_DLY : 1))
            begin
               op_done_n <= 1'b0;
               data_lines_in <= bus_ctl.irq_accept ? VEC : (bus_ctl.addr[7:0] ^ 8'ha5);
               if (bus_ctl.write && data_lines_oe)
                  wdata_seen <= data_lines_out;
            end
            else
               // undriven lines keep changing so a stale byte never matches by luck
               data_lines_in <= ~data_lines_in;
         end
         else if (!bus_ctl.request)
         begin
            cnt <= 0;
            op_done_n <= 1'b1;
            data_lines_in <= ~data_lines_in;
         end
      end
   end
endmodule

// [verif/tb_cpu_external_bus_handshake.sv]
// Purpose: self-checking bench of the external operation interface
// Assumes: half period shortened to 4 clocks, so a processor cycle is 24 clocks
// Notes: monitor checks every rising request edge against the boot fetch, the vector read or the queue of issued operations
module tb_cpu_external_bus_handshake;
   timeunit 1ns;
   timeprecision 1ps;
   import cpu_bus_pkg::*;
   localparam int HALF = 4;
   logic clk = 1'b0;
   // starts low so the first reset is a real edge and no flop sits unknown
   logic rst = 1'b0;
   logic op_valid = 1'b0;
   op_cmd_s op_cmd = '0;
   logic irq_enable = 1'b0;
   logic pause_n = 1'b1;
   logic slow = 1'b0;
   logic irq_go = 1'b0;
   logic op_ready, op_done_n, irq_request_n, data_lines_oe, write_strobe_pulse;
   logic run_status, flag_out;
   logic [7:0] data_lines_in, data_lines_out, wdata_seen;
   rd_s rd_out;
   bus_ctl_s bus_ctl, p_ctl;
   logic [29:0] p_snap;
   logic p_ack = 1'b1;
   logic exp_flag = 1'b0;
   logic boot_exp = 1'b1;
   logic chk_per = 1'b0;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int req_len = 0;
   int str_hi = 0;
   int gap = 0;
   op_cmd_s q[$];
   op_cmd_s m;
   always #2.5 clk = ~clk;
   cpu_external_bus_handshake #(.HALF_CYC(HALF)) u_dut (.clk(clk), .rst(rst),
      .op_valid(op_valid), .op_cmd(op_cmd), .op_ready(op_ready), .rd_out(rd_out),
      .irq_enable(irq_enable), .op_done_n(op_done_n), .irq_request_n(irq_request_n),
      .pause_n(pause_n), .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
      .data_lines_oe(data_lines_oe), .bus_ctl(bus_ctl),
      .write_strobe_pulse(write_strobe_pulse), .run_status(run_status), .flag_out(flag_out));
   op_responder u_dev (.clk(clk), .rst(rst), .bus_ctl(bus_ctl),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .slow(slow),
      .irq_go(irq_go), .op_done_n(op_done_n), .data_lines_in(data_lines_in),
      .irq_request_n(irq_request_n), .wdata_seen(wdata_seen));
   task automatic print_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         print_verdict();
      end
   end
   // monitor: pre-edge samples of registered outputs, so no ordering race
   always @(posedge clk)
   begin
      gap++;
      if (rst)
         cmp(bus_ctl.request, 0, "request during reset");
      else if (bus_ctl.request && !p_ctl.request)
      begin
         if (chk_per)
            cmp(gap, 6 * HALF, "processor cycle length");
         gap = 0;
         if (boot_exp)
            cmp({bus_ctl.mem_io, bus_ctl.write, bus_ctl.irq_accept, bus_ctl.addr}, 18'h20000,
               "boot fetch");
         else if (bus_ctl.irq_accept)
         begin
            cmp({bus_ctl.mem_io, bus_ctl.write, bus_ctl.addr[14]}, 0, "vector qualifiers");
            cmp(q.size(), 0, "interrupt inside instruction");
         end
         else
         begin
            m = q.pop_front();
            cmp(bus_ctl.mem_io, m.form == form_mem, "memory qualifier");
            cmp({bus_ctl.write, data_lines_oe, write_strobe_pulse}, {m.write, m.write, !m.write},
               "direction");
            if (m.write)
               cmp(data_lines_out, m.wdata, "write data");
            if (m.form == form_mem)
               cmp(bus_ctl.addr, m.addr, "memory address");
            else
               cmp(bus_ctl.addr[13], m.form == form_io_ext, "two byte flag");
            if (m.form inside {form_io_ctrl, form_io_data})
               cmp(bus_ctl.addr[14], m.form == form_io_data, "data control");
            if (m.form == form_io_ext)
               cmp(bus_ctl.addr[7:0], m.addr[7:0], "device address");
         end
         boot_exp = 1'b0;
      end
      else if (bus_ctl.request)
         cmp({bus_ctl, data_lines_out, data_lines_oe, run_status, flag_out}, p_snap,
            "outputs moved");
      else if (p_ctl.request)
      begin
         if (!slow)
            cmp(req_len, 3 * HALF, "request high time");
         else
            cmp(req_len > 30, 1, "request ended early");
         cmp(str_hi, p_ctl.write ? HALF : req_len, "strobe high time");
         cmp(p_ack, 0, "request dropped without acknowledge");
      end
      req_len = bus_ctl.request ? req_len + 1 : 0;
      str_hi = bus_ctl.request ? str_hi + int'(write_strobe_pulse) : 0;
      p_snap = {bus_ctl, data_lines_out, data_lines_oe, run_status, flag_out};
      p_ctl = bus_ctl;
      p_ack = op_done_n;
   end
   function automatic op_cmd_s mk(op_form_e f, logic w, logic l, logic h);
      op_cmd_s c;
      c = '0;
      c.form = f;
      c.write = w;
      c.last = l;
      c.halt = h;
      c.addr = 15'($urandom);
      c.wdata = 8'($urandom);
      c.flag_wr = 1'($urandom);
      c.flag_val = 1'($urandom);
      return c;
   endfunction
   task automatic do_op(input op_cmd_s c);
      q.push_back(c);
      op_valid <= 1'b1;
      op_cmd <= c;
      do @(posedge clk); while (op_ready !== 1'b1);
      op_valid <= 1'b0;
      if (c.write)
      begin
         do @(posedge clk); while (bus_ctl.request !== 1'b0);
         cmp(wdata_seen, c.wdata, "written byte");
      end
      else
      begin
         do @(posedge clk); while (rd_out.valid !== 1'b1);
         cmp(rd_out.data, (c.form inside {form_mem, form_io_ext}) ? c.addr[7:0] ^ 8'ha5 : 8'ha5,
            "read byte");
      end
      if (c.flag_wr && c.last)
         exp_flag = c.flag_val;
      repeat (2) @(posedge clk);
      cmp(flag_out, exp_flag, "flag output");
   endtask
   task automatic do_reset();
      boot_exp = 1'b1;
      exp_flag = 1'b0;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      do @(posedge clk); while (rd_out.valid !== 1'b1);
      cmp({rd_out.boot, rd_out.data}, {1'b1, 8'ha5}, "boot byte");
   endtask
   task automatic pulse(input logic en, input logic go);
      irq_enable <= en;
      irq_go <= go;
      @(posedge clk);
      irq_enable <= 1'b0;
      irq_go <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_vec();
      do @(posedge clk); while (rd_out.valid !== 1'b1);
      cmp({rd_out.vector, rd_out.data}, {1'b1, 8'h3c}, "interrupt vector");
   endtask
   initial
   begin
      void'($urandom(93));
      do_reset();
      for (int i = 0; i < 8; i++)
         do_op(mk(op_form_e'(i % 4), i / 4, 1'b1, 1'b0));
      for (int i = 0; i < 12; i++)
      begin
         chk_per = (i > 0);
         do_op(mk(op_form_e'($urandom_range(0, 3)), 1'($urandom), 1'b1, 1'b0));
      end
      chk_per = 1'b0;
      slow <= 1'b1;
      do_op(mk(form_mem, 1'b0, 1'b1, 1'b0));
      do_op(mk(form_io_ext, 1'b1, 1'b1, 1'b0));
      slow <= 1'b0;
      pulse(1'b1, 1'b1);
      do_op(mk(form_mem, 1'b0, 1'b0, 1'b0));
      do_op(mk(form_io_data, 1'b1, 1'b1, 1'b0));
      wait_vec();
      pulse(1'b1, 1'b0);
      do_op(mk(form_mem, 1'b0, 1'b1, 1'b1));
      repeat (30) @(posedge clk);
      cmp(run_status, 0, "halt wait");
      pulse(1'b0, 1'b1);
      wait_vec();
      cmp(run_status, 1, "halt left on interrupt");
      pause_n <= 1'b0;
      do_op(mk(form_io_ctrl, 1'b0, 1'b1, 1'b0));
      repeat (30) @(posedge clk);
      cmp(run_status, 0, "pause wait");
      pause_n <= 1'b1;
      repeat (3) @(posedge clk);
      cmp(run_status, 1, "pause released");
      pause_n <= 1'b0;
      do_reset();
      repeat (4) @(posedge clk);
      cmp(run_status, 0, "wait after boot fetch");
      pause_n <= 1'b1;
      repeat (3) @(posedge clk);
      cmp(run_status, 1, "run after pause");
      do_op(mk(form_mem, 1'b1, 1'b1, 1'b0));
      print_verdict();
   end
endmodule
